// ---- logic/pdc_pkg.sv ----
// Package for the phase comparator control register bank
package pdc_pkg;

  // ----------------------------------------
  // Bus and port widths
  // ----------------------------------------
  localparam int PDC_ADDR_W = 8;
  localparam int PDC_DATA_W = 32;
  localparam int PDC_REG_W = 24;
  localparam int PDC_RATIO_W = 19;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [PDC_ADDR_W-1:0] PDC_CTRL_IDX = 8'h0b;
  localparam logic [PDC_ADDR_W-1:0] PDC_CTRL_ADDR = 8'h2c;
  localparam logic [PDC_REG_W-1:0] PDC_CTRL_RESET = 24'hf8061;
  localparam logic [PDC_DATA_W-PDC_REG_W-1:0] PDC_RD_PAD = 8'h00;
  localparam logic [PDC_DATA_W-1:0] PDC_RD_NONE = 32'h0000_0000;

  // ----------------------------------------
  // Field layout, msb first
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] divider_pulse_width;
    logic spare;
    logic [1:0] counter_clock_gating;
    logic [1:0] opamp_bias;
    logic [2:0] prescaler_bias;
    logic pump_midrail_force;
    logic force_down;
    logic force_up;
    logic [1:0] slip_prevention_mode;
    logic down_pulse_enable;
    logic up_pulse_enable;
    logic polarity_flip;
    logic comparator_input_short;
    logic [2:0] reset_delay_select;
  } pdc_cfg_t;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [1:0] PDC_SLIP_OFF = 2'h0;
  localparam logic [1:0] PDC_SLIP_LOW = 2'h1;
  localparam logic [1:0] PDC_SLIP_MID = 2'h2;
  localparam logic [1:0] PDC_GATE_LT32 = 2'h0;
  localparam logic [1:0] PDC_GATE_LT128 = 2'h1;
  localparam logic [1:0] PDC_GATE_LT1023 = 2'h2;
  localparam logic [1:0] PDC_GATE_ALL_ON = 2'h3;
  localparam logic [PDC_RATIO_W-1:0] PDC_RATIO_32 = 19'h00020;
  localparam logic [PDC_RATIO_W-1:0] PDC_RATIO_128 = 19'h00080;
  localparam logic [PDC_RATIO_W-1:0] PDC_RATIO_1023 = 19'h003ff;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int PDC_CLK_PERIOD_PS = 8000;
  localparam int PDC_SLIP_LOW_NS = 6;
  localparam int PDC_SLIP_MID_NS = 14;
  localparam int PDC_SLIP_HIGH_NS = 24;
  localparam int PDC_SLIP_LOW_CYC_I =
    (PDC_SLIP_LOW_NS * 1000 + PDC_CLK_PERIOD_PS - 1) / PDC_CLK_PERIOD_PS;
  localparam int PDC_SLIP_MID_CYC_I =
    (PDC_SLIP_MID_NS * 1000 + PDC_CLK_PERIOD_PS - 1) / PDC_CLK_PERIOD_PS;
  localparam int PDC_SLIP_HIGH_CYC_I =
    (PDC_SLIP_HIGH_NS * 1000 + PDC_CLK_PERIOD_PS - 1) / PDC_CLK_PERIOD_PS;
  localparam logic [2:0] PDC_SLIP_LOW_CYC = 3'(PDC_SLIP_LOW_CYC_I);
  localparam logic [2:0] PDC_SLIP_MID_CYC = 3'(PDC_SLIP_MID_CYC_I);
  localparam logic [2:0] PDC_SLIP_HIGH_CYC = 3'(PDC_SLIP_HIGH_CYC_I);
  localparam logic [2:0] PDC_CNT_MAX = 3'h7;
  localparam logic [2:0] PDC_CNT_ONE = 3'h1;

endpackage : pdc_pkg

// ---- logic/pdc_edge_sync.sv ----
// Two-stage pin synchroniser with rising edge detect
`timescale 1ns/1ps
module pdc_edge_sync
  import pdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic rise_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } pdc_sync_st_t;

  pdc_sync_st_t st_q;
  pdc_sync_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.meta = pin_i;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_o = st_q.sync & ~st_q.prev;

endmodule : pdc_edge_sync

// ---- logic/pdc_pulse_stretch.sv ----
// Divider output pulse of selectable width
`timescale 1ns/1ps
module pdc_pulse_stretch
  import pdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic trig_i,
  input wire logic [1:0] width_i,
  output logic pulse_o
);

  typedef struct packed {
    logic [2:0] cnt;
    logic pulse;
  } pdc_pulse_st_t;

  pdc_pulse_st_t st_q;
  pdc_pulse_st_t st_d;

  // Width code 0 gives one cycle, 3 gives four
  always_comb begin
    st_d = st_q;
    if (trig_i) begin
      st_d.cnt = {1'b0, width_i};
      st_d.pulse = 1'b1;
    end else if (st_q.cnt != 3'h0) begin
      st_d.cnt = st_q.cnt - PDC_CNT_ONE;
      st_d.pulse = 1'b1;
    end else begin
      st_d.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse_o = st_q.pulse;

endmodule : pdc_pulse_stretch

// ---- logic/pdc_ctrl.sv ----
// Phase comparator control register and comparator test logic
// Overview of operation
// - Three-bit reset delay select in bits 2:0, reset 1.
// - Bit 3 ties both comparator inputs together for test, reset 0.
// - Bit 4 reverses comparator sense, reset 0.
// - Bit 5 enables up pulses, reset 1; force-up overrides.
// - Bit 6 enables down pulses, reset 1; force-down overrides.
// - Bits 8:7 slip mode: off, or boost past 6, 14, 24 ns.
// - Bit 9 holds pump up output on, reset 0.
// - Bit 10 holds pump down output on, reset 0.
// - Bit 11 forces pump output to mid rail, reset 0.
// - Three-bit prescaler bias in bits 14:12, reset 0.
// - Two-bit op-amp bias in bits 16:15, reset 3.
// - Bits 18:17 gate counter below ratio 32, 128, 1023, or never.
// - Bits 21:20 set divider pulse width, shortest to longest.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module pdc_ctrl
  import pdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [PDC_ADDR_W-1:0] addr_i,
  input wire logic [PDC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [PDC_DATA_W-1:0] rdata_o,
  input wire logic ref_i,
  input wire logic div_i,
  input wire logic [PDC_RATIO_W-1:0] div_ratio_i,
  output pdc_cfg_t cfg_o,
  output logic pump_up_o,
  output logic pump_down_o,
  output logic pump_midrail_o,
  output logic slip_boost_up_o,
  output logic slip_boost_down_o,
  output logic counter_clock_on_o,
  output logic div_pulse_o,
  output logic [2:0] prescaler_bias_o,
  output logic [1:0] opamp_bias_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pdc_cfg_t cfg;
    logic [PDC_DATA_W-1:0] rdata;
    logic up;
    logic down;
    logic [2:0] rst_cnt;
    logic [2:0] err_cnt;
    logic pump_up;
    logic pump_down;
    logic boost_up;
    logic boost_down;
    logic clock_on;
  } pdc_st_t;

  pdc_st_t st_q;
  pdc_st_t st_d;

  logic ref_rise;
  logic div_rise;
  logic hit;
  logic set_up;
  logic set_down;
  logic both;
  logic clear;
  logic err;
  logic [2:0] slip_thr;
  logic gate_off;
  logic [PDC_RATIO_W-1:0] gate_limit;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pdc_edge_sync u_ref_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(ref_i),
    .rise_o(ref_rise)
  );

  pdc_edge_sync u_div_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(div_i),
    .rise_o(div_rise)
  );

  // ----------------------------------------
  // Divider output pulse
  // ----------------------------------------
  pdc_pulse_stretch u_div_pulse (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .trig_i(div_rise),
    .width_i(st_q.cfg.divider_pulse_width),
    .pulse_o(div_pulse_o)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    hit = (addr_i == PDC_CTRL_ADDR);
    // Shorted inputs make both sides see the reference edge
    set_up = st_q.cfg.comparator_input_short ? ref_rise :
      (st_q.cfg.polarity_flip ? div_rise : ref_rise);
    set_down = st_q.cfg.comparator_input_short ? ref_rise :
      (st_q.cfg.polarity_flip ? ref_rise : div_rise);
    both = st_q.up & st_q.down;
    clear = both & (st_q.rst_cnt >= st_q.cfg.reset_delay_select);
    err = st_q.up ^ st_q.down;
    unique case (st_q.cfg.slip_prevention_mode)
      PDC_SLIP_OFF: slip_thr = PDC_CNT_MAX;
      PDC_SLIP_LOW: slip_thr = PDC_SLIP_LOW_CYC;
      PDC_SLIP_MID: slip_thr = PDC_SLIP_MID_CYC;
      default: slip_thr = PDC_SLIP_HIGH_CYC;
    endcase
    unique case (st_q.cfg.counter_clock_gating)
      PDC_GATE_LT32: gate_limit = PDC_RATIO_32;
      PDC_GATE_LT128: gate_limit = PDC_RATIO_128;
      PDC_GATE_LT1023: gate_limit = PDC_RATIO_1023;
      PDC_GATE_ALL_ON: gate_limit = '0;
    endcase
    gate_off = (st_q.cfg.counter_clock_gating != PDC_GATE_ALL_ON) &&
      (div_ratio_i < gate_limit);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    // Register write and read
    if (wr_i && hit) begin
      st_d.cfg = pdc_cfg_t'(wdata_i[PDC_REG_W-1:0]);
    end
    if (rd_i) begin
      st_d.rdata = hit ? {PDC_RD_PAD, st_q.cfg} : PDC_RD_NONE;
    end else begin
      st_d.rdata = st_q.rdata;
    end
    // Comparator latches; a new edge wins over the reset clear
    st_d.up = (st_q.up & ~clear) | set_up;
    st_d.down = (st_q.down & ~clear) | set_down;
    if (both && !clear) begin
      st_d.rst_cnt = st_q.rst_cnt + PDC_CNT_ONE;
    end else begin
      st_d.rst_cnt = '0;
    end
    // Phase error duration
    if (err) begin
      st_d.err_cnt = (st_q.err_cnt == PDC_CNT_MAX) ? st_q.err_cnt : st_q.err_cnt + PDC_CNT_ONE;
    end else begin
      st_d.err_cnt = '0;
    end
    st_d.boost_up = (st_q.cfg.slip_prevention_mode != PDC_SLIP_OFF) && err && st_q.up &&
      (st_q.err_cnt >= slip_thr);
    st_d.boost_down = (st_q.cfg.slip_prevention_mode != PDC_SLIP_OFF) && err && st_q.down &&
      (st_q.err_cnt >= slip_thr);
    // Pump outputs
    st_d.pump_up = (st_q.up & st_q.cfg.up_pulse_enable) | st_q.cfg.force_up;
    st_d.pump_down = (st_q.down & st_q.cfg.down_pulse_enable) | st_q.cfg.force_down;
    st_d.clock_on = ~gate_off;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q.cfg <= PDC_CTRL_RESET;
      st_q.rdata <= '0;
      st_q.up <= 1'b0;
      st_q.down <= 1'b0;
      st_q.rst_cnt <= '0;
      st_q.err_cnt <= '0;
      st_q.pump_up <= 1'b0;
      st_q.pump_down <= 1'b0;
      st_q.boost_up <= 1'b0;
      st_q.boost_down <= 1'b0;
      st_q.clock_on <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o = st_q.rdata;
  assign cfg_o = st_q.cfg;
  assign pump_up_o = st_q.pump_up;
  assign pump_down_o = st_q.pump_down;
  assign pump_midrail_o = st_q.cfg.pump_midrail_force;
  assign slip_boost_up_o = st_q.boost_up;
  assign slip_boost_down_o = st_q.boost_down;
  assign counter_clock_on_o = st_q.clock_on;
  assign prescaler_bias_o = st_q.cfg.prescaler_bias;
  assign opamp_bias_o = st_q.cfg.opamp_bias;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  property p_reset_value;
    $fell(srst_i) |-> (cfg_o == PDC_CTRL_RESET) && !pump_up_o && !pump_down_o;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("Control register not at reset value");

  property p_write_store;
    (wr_i && hit) |=> (cfg_o == $past(wdata_i[PDC_REG_W-1:0]));
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("Write did not update control register");

  property p_read_back;
    (rd_i && hit && !wr_i) |=> (rdata_o == {PDC_RD_PAD, $past(cfg_o)});
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("Read data does not match register");

  property p_read_unmapped;
    (rd_i && !hit) |=> (rdata_o == PDC_RD_NONE);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("Unmapped read not zero");

  property p_force_up;
    (cfg_o.force_up && !wr_i) [*2] |-> pump_up_o;
  endproperty
  a_force_up: assert property (p_force_up)
    else $error("Forced up not held on");

  property p_force_down;
    (cfg_o.force_down && !wr_i) [*2] |-> pump_down_o;
  endproperty
  a_force_down: assert property (p_force_down)
    else $error("Forced down not held on");

  property p_up_gate;
    (!cfg_o.up_pulse_enable && !cfg_o.force_up) |=> !pump_up_o;
  endproperty
  a_up_gate: assert property (p_up_gate)
    else $error("Up pulse passed while disabled");

  property p_down_gate;
    (!cfg_o.down_pulse_enable && !cfg_o.force_down) |=> !pump_down_o;
  endproperty
  a_down_gate: assert property (p_down_gate)
    else $error("Down pulse passed while disabled");

  property p_slip_off;
    (cfg_o.slip_prevention_mode == PDC_SLIP_OFF) |=> !slip_boost_up_o && !slip_boost_down_o;
  endproperty
  a_slip_off: assert property (p_slip_off)
    else $error("Slip boost active while disabled");

  property p_gate_all_on;
    (cfg_o.counter_clock_gating == PDC_GATE_ALL_ON) |=> counter_clock_on_o;
  endproperty
  a_gate_all_on: assert property (p_gate_all_on)
    else $error("Counter gated while all clocks on");

  property p_gate_low_ratio;
    (cfg_o.counter_clock_gating == PDC_GATE_LT32 && div_ratio_i < PDC_RATIO_32)
      |=> !counter_clock_on_o;
  endproperty
  a_gate_low_ratio: assert property (p_gate_low_ratio)
    else $error("Counter running below ratio 32");

  property p_short_no_error;
    (cfg_o.comparator_input_short && !st_q.up && !st_q.down) |=> !(st_q.up ^ st_q.down);
  endproperty
  a_short_no_error: assert property (p_short_no_error)
    else $error("Shorted inputs produced phase error");

  property p_hold_delay;
    (st_q.up && st_q.down && (st_q.rst_cnt < cfg_o.reset_delay_select))
      |=> st_q.up && st_q.down;
  endproperty
  a_hold_delay: assert property (p_hold_delay)
    else $error("Comparator latches cleared before reset delay");

  property p_clear_delay;
    (st_q.up && st_q.down && (st_q.rst_cnt >= cfg_o.reset_delay_select) && !set_up)
      |=> !st_q.up;
  endproperty
  a_clear_delay: assert property (p_clear_delay)
    else $error("Comparator latches not cleared after reset delay");

  property p_ref_sets_up;
    (!cfg_o.comparator_input_short && !cfg_o.polarity_flip && ref_rise) |=> st_q.up;
  endproperty
  a_ref_sets_up: assert property (p_ref_sets_up)
    else $error("Reference edge did not set up latch");

  property p_div_pulse_start;
    div_rise |=> div_pulse_o;
  endproperty
  a_div_pulse_start: assert property (p_div_pulse_start)
    else $error("Divider edge gave no output pulse");

endmodule : pdc_ctrl

// ---- dv/phase_detector_control_register_bench.sv ----
// Self-checking bench for the phase comparator control register
`timescale 1ns/1ps
module phase_detector_control_register_bench
  import pdc_pkg::*;
;

  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  localparam logic [23:0] RST_V = 24'h0f8061;
  localparam logic [23:0] NRM_V = 24'h0f8060;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [PDC_ADDR_W-1:0] addr_i = 8'h00;
  logic [PDC_DATA_W-1:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ref_i = 1'b0;
  logic div_i = 1'b0;
  logic [PDC_RATIO_W-1:0] div_ratio_i = 19'h00000;
  logic [PDC_DATA_W-1:0] rdata_o;
  pdc_cfg_t cfg_o;
  logic pump_up_o, pump_down_o, pump_midrail_o, slip_boost_up_o, slip_boost_down_o;
  logic counter_clock_on_o, div_pulse_o;
  logic [2:0] prescaler_bias_o;
  logic [1:0] opamp_bias_o;
  logic [5:0] obs;
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] rv;
  logic [5:0] seen;
  int hi;
  logic [18:0] lim [3];
  int cnt_bit = 4;

  assign obs = {counter_clock_on_o, div_pulse_o, slip_boost_down_o, slip_boost_up_o,
                pump_down_o, pump_up_o};

  always #4 clk_i = ~clk_i;

  pdc_ctrl dut_u (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref_i(ref_i), .div_i(div_i),
    .div_ratio_i(div_ratio_i), .cfg_o(cfg_o), .pump_up_o(pump_up_o),
    .pump_down_o(pump_down_o), .pump_midrail_o(pump_midrail_o),
    .slip_boost_up_o(slip_boost_up_o), .slip_boost_down_o(slip_boost_down_o),
    .counter_clock_on_o(counter_clock_on_o), .div_pulse_o(div_pulse_o),
    .prescaler_bias_o(prescaler_bias_o), .opamp_bias_o(opamp_bias_o));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic pins(input logic r, input logic d);
    @(posedge clk_i);
    ref_i <= r;
    div_i <= d;
  endtask : pins

  task automatic watch(input int n, output logic [5:0] s, output int h);
    s = 6'h00;
    h = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      s = s | obs;
      if (obs[cnt_bit] === 1'b1) h++;
    end
  endtask : watch

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    lim[0] = 19'h00020;
    lim[1] = 19'h00080;
    lim[2] = 19'h003ff;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    // Reset values
    rd(8'h2c, rv);
    chk("reset read", {8'h00, RST_V}, rv);
    chk("reset cfg", {8'h00, RST_V}, {8'h00, cfg_o});
    chk("reset opamp", 32'h3, {30'h0, opamp_bias_o});
    chk("reset psbias", 32'h0, {29'h0, prescaler_bias_o});
    chk("reset pumps", 32'h20, {26'h0, obs});
    // Read back patterns, unmapped places
    for (int i = 0; i < 4; i++) begin
      rv = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h00a5_a5a5 :
           (i == 2) ? 32'h005a_5a5a : 32'h0000_0000;
      wr(8'h2c, rv);
      wr(8'h2d, ~rv);
      #1;
      chk("opamp", {30'h0, rv[16:15]}, {30'h0, opamp_bias_o});
      chk("psbias", {29'h0, rv[14:12]}, {29'h0, prescaler_bias_o});
      chk("midrail", {31'h0, rv[11]}, {31'h0, pump_midrail_o});
      chk("cfg", {8'h00, rv[23:0]}, {8'h00, cfg_o});
      rd(8'h2c, rv);
      chk("readback", {8'h00, (i == 0) ? 24'hffffff : (i == 1) ? 24'ha5a5a5 :
          (i == 2) ? 24'h5a5a5a : 24'h000000}, rv);
      rd(8'h0b, rv);
      chk("unmapped read", 32'h0, rv);
    end
    // Comparator pairing, polarity and short
    wr(8'h2c, {8'h00, NRM_V});
    pins(1'b1, 1'b0);
    watch(8, seen, hi);
    chk("ref sets up", 32'h1, {30'h0, seen[1:0]});
    pins(1'b1, 1'b1);
    watch(8, seen, hi);
    chk("both cleared", 32'h0, {30'h0, obs[1:0]});
    pins(1'b0, 1'b0);
    wr(8'h2c, {8'h00, NRM_V | 24'h000010});
    pins(1'b1, 1'b0);
    watch(8, seen, hi);
    chk("flip ref sets down", 32'h2, {30'h0, seen[1:0]});
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b0);
    wr(8'h2c, {8'h00, NRM_V | 24'h000008});
    pins(1'b1, 1'b0);
    watch(8, seen, hi);
    chk("short sets both", 32'h3, {30'h0, seen[1:0]});
    pins(1'b0, 1'b0);
    // Delay code 3 holds both latches four cycles
    wr(8'h2c, {8'h00, NRM_V | 24'h00000b});
    cnt_bit = 0;
    pins(1'b1, 1'b0);
    watch(10, seen, hi);
    chk("reset delay", 32'h4, 32'(hi));
    cnt_bit = 4;
    pins(1'b0, 1'b0);
    // Enable mask and force bits
    wr(8'h2c, {8'h00, NRM_V & 24'hffffdf});
    pins(1'b1, 1'b0);
    watch(8, seen, hi);
    chk("up masked", 32'h0, {31'h0, seen[0]});
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b0);
    wr(8'h2c, {8'h00, (NRM_V & 24'hffffdf) | 24'h000200});
    watch(4, seen, hi);
    chk("force up", 32'h1, {30'h0, obs[1:0]});
    wr(8'h2c, {8'h00, (NRM_V & 24'hffffbf) | 24'h000400});
    watch(4, seen, hi);
    chk("force down", 32'h2, {30'h0, obs[1:0]});
    // Slip prevention modes, slow edges only
    for (int m = 0; m < 4; m++) begin
      wr(8'h2c, {8'h00, NRM_V | (24'(m) << 7)});
      pins(1'b1, 1'b0);
      watch(10, seen, hi);
      chk("slip boost up", {31'h0, m != 0}, {31'h0, seen[2]});
      pins(1'b1, 1'b1);
      pins(1'b0, 1'b0);
      watch(6, seen, hi);
      pins(1'b0, 1'b1);
      watch(10, seen, hi);
      chk("slip boost down", {31'h0, m != 0}, {31'h0, seen[3]});
      pins(1'b1, 1'b1);
      pins(1'b0, 1'b0);
      watch(6, seen, hi);
    end
    // Divider pulse width
    for (int w = 0; w < 4; w++) begin
      wr(8'h2c, {8'h00, RST_V | (24'(w) << 20)});
      pins(1'b0, 1'b1);
      watch(12, seen, hi);
      chk("pulse width", 32'(w + 1), 32'(hi));
      pins(1'b0, 1'b0);
      watch(4, seen, hi);
    end
    // Counter clock gating
    for (int m = 0; m < 3; m++) begin
      wr(8'h2c, {8'h00, (RST_V & 24'hf9ffff) | (24'(m) << 17)});
      div_ratio_i <= lim[m] - 19'h00001;
      watch(4, seen, hi);
      chk("gated below", 32'h0, {31'h0, obs[5]});
      div_ratio_i <= lim[m];
      watch(4, seen, hi);
      chk("running at limit", 32'h1, {31'h0, obs[5]});
    end
    wr(8'h2c, {8'h00, RST_V});
    div_ratio_i <= 19'h00000;
    watch(4, seen, hi);
    chk("all clocks on", 32'h1, {31'h0, obs[5]});
    test_done();
  end

endmodule : phase_detector_control_register_bench
